// file: logic/chan_cfg_defs.svh
// Constants for the channel configuration register bank.
// Assumes inclusion by the package and the design module by bare name.
`ifndef CHAN_CFG_DEFS_SVH
`define CHAN_CFG_DEFS_SVH

// Register byte addresses; printed indices are these divided by four.
`define MUX_CFG_INDEX 8'h14
`define CH_CFG_INDEX 8'h15
`define MUX_CFG_ADDR 8'h50
`define CH_CFG_ADDR 8'h54
// Status register of effective settings, placed after the two.
`define EFF_STAT_ADDR 8'h58
`define GEN_CFG_ADDR 8'h40

// Field positions.
`define INVERT_BIT 23
`define ISO_POS_BIT 21
`define ISO_NEG_BIT 20
`define RATE_HI 23
`define RATE_LO 22
`define GAIN_HI 17
`define GAIN_LO 16
`define HPF_BIT 14
`define LPF_HI 13
`define LPF_LO 12
`define MCLK_HI 21
`define MCLK_LO 20

// Reset values.
`define MUX_CFG_RESET 24'h30_0000
`define CH_CFG_RESET 24'h80_5000
`define GEN_CFG_RESET 24'h00_0000
// Writable bits of each register.
`define MUX_CFG_MASK 24'hB0_0000
`define CH_CFG_MASK 24'hC3_7000
`define GEN_CFG_MASK 24'h30_0000

// Codes.
`define RATE_FAST 2'h0
`define RATE_MID 2'h1
`define RATE_SLOW 2'h2
`define RATE_RSVD 2'h3
`define LPF_BYPASS 2'h0
`define LPF_40 2'h1
`define LPF_100 2'h2
`define LPF_150 2'h3
`define MCLK_32768 2'h0
`define MCLK_32000 2'h1
`define MCLK_32000_B 2'h2
`define MCLK_31968 2'h3

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: logic/chan_cfg_pkg.sv
// Types shared by the channel configuration register bank.
// Assumes the defines header sits beside it.
`include "chan_cfg_defs.svh"
package chan_cfg_pkg;
    // Effective channel settings presented to the analog and filter logic.
    typedef struct packed {
        logic input_invert; // Channel sign flip.
        logic isolate_pos_input; // Positive electrode switch open.
        logic isolate_neg_input; // Negative electrode switch open.
        logic [1:0] gain_code; // 20/40/80/160 V/V.
        logic highpass_select; // 0.5 Hz high-pass on.
        logic [1:0] lowpass_select; // Effective low-pass code.
        logic [1:0] rate_code; // Effective sample-rate code.
        logic [1:0] master_clock_select; // Master clock choice.
        logic rate_valid; // Written rate legal for clock.
    } chan_settings_t;
    // Sample-rate class used by the low-pass check.
    typedef enum logic [1:0] {
        CLS_FULL = 2'h0, // 512 or 500 sps.
        CLS_HALF = 2'h1, // 256 or 250 sps.
        CLS_LOW = 2'h3, // 128, 125, 200 or 199.8 sps.
        CLS_BAD = 2'h2 // Reserved code, or fast or mid code on clock 10 or 11.
    } rate_class_t;
endpackage

// file: logic/biopotential_channel_config.sv
// Input multiplexer and channel configuration registers on AXI4-Lite.
// Assumes one 20 MHz clock and a synchronous active-low reset.
//
// Overview of operation
// - Polarity bit: 0 normal, 1 inverted.
// - Positive isolate bit, resets isolated.
// - Negative isolate bit, resets isolated.
// - Rate field resets 10, clock dependent.
// - 32768 Hz: 512, 256, 128 sps.
// - 32000 Hz: 500, 250, 125 sps.
// - Clock 10: only code 10, 200 sps.
// - Clock 11: only code 10, 199.8 sps.
// - Gain codes 20 to 160 V/V, reset 00.
// - High-pass bit bypasses or 0.5 Hz, reset 1.
// - Low-pass 00 bypass, reset 01.
// - Low rates reduce all filtered codes.
// - 100 Hz only at two fastest rates.
// - 150 Hz only at fastest rate.
// - Unsupported low-pass applies 01, register unchanged.
// - Read returns effective low-pass code.
// - Channel writes may break sample continuity.
// - Unsupported combinations map to defaults.
// - Master clock field picks master frequency.
`include "chan_cfg_defs.svh"
module biopotential_channel_config (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output chan_cfg_pkg::chan_settings_t settings,
    output logic chan_restart
);

    // Stored register contents, as written.
    logic [23:0] mux_cfg_reg;
    logic [23:0] ch_cfg_reg;
    logic [23:0] gen_cfg_reg;

    // Write channel capture; address and data may arrive in either order.
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic restart_reg;
    // Ready flags are kept as flops of their own so every output leaves a flip-flop.
    logic awready_reg;
    logic wready_reg;
    logic arready_reg;
    chan_cfg_pkg::chan_settings_t settings_reg;

    // Applies byte enables and the writable mask to a 24-bit register.
    function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [23:0] mask);
        logic [23:0] byte_mask;
        byte_mask = {{8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = ((old & ~byte_mask) | (data[23:0] & byte_mask)) & mask;
    endfunction

    // Classifies a rate code against the master clock choice.
    function automatic chan_cfg_pkg::rate_class_t classify(input logic [1:0] mclk,
                                                           input logic [1:0] rate);
        if (rate == `RATE_SLOW) begin
            classify = chan_cfg_pkg::CLS_LOW;
        end else if (rate == `RATE_RSVD) begin
            classify = chan_cfg_pkg::CLS_BAD;
        end else if (mclk == `MCLK_32768 || mclk == `MCLK_32000) begin
            classify = (rate == `RATE_FAST) ? chan_cfg_pkg::CLS_FULL
                                            : chan_cfg_pkg::CLS_HALF;
        end else begin
            classify = chan_cfg_pkg::CLS_BAD;
        end
    endfunction

    // Transaction qualifiers.
    wire write_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wire read_fire = s_axi_arvalid && !rvalid_reg;
    wire wr_mux = write_fire && (awaddr_reg == `MUX_CFG_ADDR);
    wire wr_ch = write_fire && (awaddr_reg == `CH_CFG_ADDR);
    wire wr_gen = write_fire && (awaddr_reg == `GEN_CFG_ADDR);
    wire wr_ro = write_fire && (awaddr_reg == `EFF_STAT_ADDR);
    wire wr_hit = wr_mux || wr_ch || wr_gen || wr_ro;

    // Effective settings derived from the stored fields.
    wire [1:0] mclk_sel = gen_cfg_reg[`MCLK_HI:`MCLK_LO];
    wire [1:0] rate_wr = ch_cfg_reg[`RATE_HI:`RATE_LO];
    wire [1:0] lpf_wr = ch_cfg_reg[`LPF_HI:`LPF_LO];
    wire chan_cfg_pkg::rate_class_t rate_cls = classify(mclk_sel, rate_wr);
    wire rate_ok = (rate_cls != chan_cfg_pkg::CLS_BAD);
    // Reserved rate codes fall back to the default rate.
    wire [1:0] rate_eff = rate_ok ? rate_wr : `RATE_SLOW;
    wire chan_cfg_pkg::rate_class_t cls_eff = rate_ok ? rate_cls : chan_cfg_pkg::CLS_LOW;
    // 100 Hz needs full or half rate, 150 Hz needs full rate; low rates force 01.
    wire lpf_ok = (lpf_wr == `LPF_BYPASS) || (lpf_wr == `LPF_40)
                  || ((lpf_wr == `LPF_100) && (cls_eff != chan_cfg_pkg::CLS_LOW))
                  || ((lpf_wr == `LPF_150) && (cls_eff == chan_cfg_pkg::CLS_FULL));
    // At low rates code 01 itself means the reduced cutoff downstream.
    wire [1:0] lpf_eff = lpf_ok ? lpf_wr : `LPF_40;
    wire [23:0] ch_read = {ch_cfg_reg[23:14], lpf_eff, ch_cfg_reg[11:0]};
    wire [23:0] stat_read = {16'h0000, mclk_sel, rate_eff, lpf_eff, rate_ok, lpf_ok};

    // Read data selection for the decoded address.
    wire rd_mux = (s_axi_araddr == `MUX_CFG_ADDR);
    wire rd_ch = (s_axi_araddr == `CH_CFG_ADDR);
    wire rd_gen = (s_axi_araddr == `GEN_CFG_ADDR);
    wire rd_stat = (s_axi_araddr == `EFF_STAT_ADDR);
    wire rd_hit = rd_mux || rd_ch || rd_gen || rd_stat;
    wire [23:0] rd_word = rd_mux ? mux_cfg_reg : rd_ch ? ch_read
                        : rd_gen ? gen_cfg_reg : rd_stat ? stat_read : 24'h00_0000;

    // Address channel holds one address until the write completes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            awaddr_reg <= 8'h00;
        end else if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
        end else if (write_fire) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    // Data channel is captured independently of the address.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (write_fire) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    // Write response follows both halves; unmapped addresses give SLVERR.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else if (write_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Multiplexer register: polarity and the two isolation switches.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mux_cfg_reg <= `MUX_CFG_RESET;
        end else if (wr_mux) begin
            mux_cfg_reg <= merge(mux_cfg_reg, wdata_reg, wstrb_reg, `MUX_CFG_MASK);
        end
    end

    // Channel register keeps its writable bits as written, with no low-pass substitution.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ch_cfg_reg <= `CH_CFG_RESET;
        end else if (wr_ch) begin
            ch_cfg_reg <= merge(ch_cfg_reg, wdata_reg, wstrb_reg, `CH_CFG_MASK);
        end
    end

    // Master clock selection; only that field of the general register lives here.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gen_cfg_reg <= `GEN_CFG_RESET;
        end else if (wr_gen) begin
            gen_cfg_reg <= merge(gen_cfg_reg, wdata_reg, wstrb_reg, `GEN_CFG_MASK);
        end
    end

    // Any channel or clock write restarts the filter chain, so the sample
    // stream may jump; downstream logic drops its history on this pulse.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= wr_ch || wr_gen;
        end
    end

    // Registered settings for the channel, one cycle behind the registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            settings_reg <= '0;
        end else begin
            settings_reg.input_invert <= mux_cfg_reg[`INVERT_BIT];
            settings_reg.isolate_pos_input <= mux_cfg_reg[`ISO_POS_BIT];
            settings_reg.isolate_neg_input <= mux_cfg_reg[`ISO_NEG_BIT];
            settings_reg.gain_code <= ch_cfg_reg[`GAIN_HI:`GAIN_LO];
            settings_reg.highpass_select <= ch_cfg_reg[`HPF_BIT];
            settings_reg.lowpass_select <= lpf_eff;
            settings_reg.rate_code <= rate_eff;
            settings_reg.master_clock_select <= mclk_sel;
            settings_reg.rate_valid <= rate_ok;
        end
    end

    // Read channel: one read at a time, answer one cycle after acceptance.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `RESP_OKAY;
        end else if (read_fire) begin
            rvalid_reg <= 1'b1;
            arready_reg <= 1'b0;
            rdata_reg <= {8'h00, rd_word};
            rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Ready outputs mirror the inverse of the held flags, arready that of rvalid, each from its own flop.
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign settings = settings_reg;
    assign chan_restart = restart_reg;

endmodule // biopotential_channel_config

// file: test/chan_cfg_monitor.sv
// Checker for the channel configuration bank.
// Assumes it is bound to the top module and sees its ports.
module chan_cfg_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire chan_cfg_pkg::chan_settings_t settings,
    input wire logic chan_restart
);
    // One domain, so clock and reset are given once.
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A response must stand until the master takes it.
    chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    // Read answers one cycle after the address is taken.
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // Both write halves together give a response two cycles on.
    chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
        else $error("unused bits read nonzero");
    chk_restart_pulse: assert property (chan_restart |=> !chan_restart)
        else $error("restart longer than a cycle");
    // Slow rates never carry the wide low-pass settings.
    chk_slow_lpf: assert property (settings.rate_code == 2'h2 |-> settings.lowpass_select[1] == 1'b0)
        else $error("wide low-pass at slow rate");
    chk_half_lpf: assert property (settings.rate_code == 2'h1 |-> settings.lowpass_select != 2'h3)
        else $error("150 Hz at half rate");
    chk_clock_rate: assert property (settings.master_clock_select[1] |-> settings.rate_code == 2'h2)
        else $error("bad rate for clock");
    cover property (chan_restart);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (!settings.rate_valid);
endmodule // chan_cfg_monitor

bind biopotential_channel_config chan_cfg_monitor mon (.*);

// file: test/test_biopotential_channel_config.sv
// Self-checking bench for the channel configuration bank.
// Assumes the design and the checker are compiled before it.
module test_biopotential_channel_config;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, chan_restart;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    chan_cfg_pkg::chan_settings_t settings;
    int n_fail, checked, i;
    // Cases: clock, written, read back, and {clock, rate, lpf, legal}; gain and hpf are checked against the written value.
    logic [1:0] mclk [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
    logic [23:0] chw [7] = '{24'h03_3000, 24'h42_7000, 24'h81_6000, 24'h00_2000,
        24'h00_0000, 24'h80_3000, 24'h80_3000};
    logic [23:0] chr [7] = '{24'h03_3000, 24'h42_5000, 24'h81_5000, 24'h00_2000,
        24'h00_0000, 24'h80_1000, 24'h80_1000};
    logic [6:0] st [7] = '{7'h07, 7'h0B, 7'h13, 7'h25, 7'h50, 7'h73, 7'h33};

    biopotential_channel_config DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .settings(settings), .chan_restart(chan_restart));

    // 50 ns period.
    always #25 clk = ~clk;

    task automatic report_and_stop();
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A wait that runs out ends the run as a failure.
    task automatic give_up(input int n);
        if (n >= 60) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // Both write halves are offered at once; each drops when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        give_up(n);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        check({31'h0, chan_restart}, {31'h0, (a == 8'h54 || a == 8'h40)});
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        give_up(n);
        rready <= 1'b0;
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, er});
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        n_fail = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axi_rd(8'h50, 32'h0030_0000, 2'h0);
        axi_rd(8'h54, 32'h0080_5000, 2'h0);
        axi_wr(8'h50, 32'hFFFF_FFFF, 4'hF, 2'h0);
        axi_rd(8'h50, 32'h00B0_0000, 2'h0);
        check({31'h0, settings.input_invert}, 32'h1);
        // Byte 2 strobe off leaves every field alone.
        axi_wr(8'h50, 32'h0000_0000, 4'h3, 2'h0);
        axi_rd(8'h50, 32'h00B0_0000, 2'h0);
        axi_wr(8'h50, 32'h0010_0000, 4'h4, 2'h0);
        check({30'h0, settings.isolate_pos_input, settings.isolate_neg_input}, 32'h1);
        axi_wr(8'h60, 32'h0000_FFFF, 4'hF, 2'h2);
        axi_rd(8'h60, 32'h0000_0000, 2'h2);
        for (i = 0; i < 7; i++) begin
            axi_wr(8'h40, {10'h0, mclk[i], 20'h0}, 4'hF, 2'h0);
            axi_wr(8'h54, {8'h0, chw[i]}, 4'hF, 2'h0);
            axi_rd(8'h54, {8'h0, chr[i]}, 2'h0);
            check({22'h0, settings.gain_code, settings.highpass_select, settings.master_clock_select,
                settings.rate_code, settings.lowpass_select, settings.rate_valid},
                {22'h0, chw[i][17:16], chw[i][14], st[i]});
        end
        report_and_stop();
    end
endmodule // test_biopotential_channel_config
